/* File: design/mis_pkg.sv */
// mis_pkg: constants, encodings and carriers of the instruction sequencer.
// assumes a 16-bit program word, 8-bit data memory and an 11-bit program counter.
package mis_pkg;

	// ----------------------------------------------------------------
	// widths and fixed values
	// ----------------------------------------------------------------
	localparam int          PC_W         = 11;
	localparam int          DATA_W       = 8;
	localparam int          INSTR_W      = 16;
	localparam int          BIDX_W       = 3;
	localparam int          PH_COUNT     = 4;      // system clocks per instruction cycle
	localparam int          DEST_SEL_BIT = 0;      // bidx bit choosing memory as destination
	localparam logic [7:0]  PCL_ADDR     = 8'h06;  // data address that aliases program_counter_low
	localparam logic [10:0] RESET_VECTOR = 11'h000;
	localparam logic [10:0] PC_STEP      = 11'h001;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [7:0]  BIT_ONE      = 8'h01;
	localparam logic [8:0]  BYTE_MAX     = 9'h0FF;

	// ----------------------------------------------------------------
	// state encodings
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_T1 = 4'h1,
		PH_T2 = 4'h2,
		PH_T3 = 4'h4,
		PH_T4 = 4'h8
	} mis_phase_t;

	// kind of the extra instruction cycle that follows a two-cycle instruction
	typedef enum logic [3:0] {
		BUB_NONE  = 4'h1,
		BUB_SKIP  = 4'h2,
		BUB_HOLD  = 4'h4,
		BUB_TABLE = 4'h8
	} mis_bub_t;

	typedef enum logic [4:0] {
		OP_NOP     = 5'h00, OP_MOV_A_M = 5'h01, OP_MOV_M_A = 5'h02, OP_MOV_A_X = 5'h03,
		OP_ADD_M   = 5'h04, OP_SUB_M   = 5'h05, OP_ADD_X   = 5'h06, OP_SUB_X   = 5'h07,
		OP_AND_M   = 5'h08, OP_OR_M    = 5'h09, OP_XOR_M   = 5'h0A, OP_CPL     = 5'h0B,
		OP_INC     = 5'h0C, OP_DEC     = 5'h0D, OP_RR      = 5'h0E, OP_RL      = 5'h0F,
		OP_RRC     = 5'h10, OP_RLC     = 5'h11, OP_CLR_BIT = 5'h12, OP_SET_BIT = 5'h13,
		OP_SZ      = 5'h14, OP_SZ_BIT  = 5'h15, OP_SNZ_BIT = 5'h16, OP_JMP     = 5'h17,
		OP_CALL    = 5'h18, OP_RET     = 5'h19, OP_INTERRUPT_RETURN_OP    = 5'h1A, OP_TABRD   = 5'h1B,
		OP_HALT    = 5'h1C, OP_WDT_PC1 = 5'h1D, OP_WDT_PC2 = 5'h1E, OP_AND_X   = 5'h1F
	} mis_op_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		mis_op_t                 op;
		logic [BIDX_W-1:0]       bidx;  // bit index, or bit 0 = destination is memory
		logic [DATA_W-1:0]       m;     // data address or immediate
	} mis_instr_t;

	typedef struct packed {
		logic [DATA_W-1:0]       addr;
		logic [DATA_W-1:0]       wdata;
		logic                    we;
	} mis_dmem_req_t;

	typedef struct packed {
		logic [DATA_W-1:0]       acc;
		logic [DATA_W-1:0]       tbl_high;
		logic                    carry;
		logic                    zero;
		logic                    gie;
		logic                    wdt_to;
		logic                    power_down_flag;
		logic                    power_down;
	} mis_status_t;

endpackage

/* File: design/mis_sequencer.sv */
// mis_sequencer: instruction fetch, decode and execute of the 8-bit accumulator core.
// assumes program and data memories on clk_sys_i, read data valid one phase after address.
//
// Function
// - four system clocks form one instruction cycle
// - jump, call, returns, table read: two cycles
// - writing program_counter_low costs one extra cycle
// - skip taken costs one extra cycle
// - skip tests byte or bit, skips next
// - call saves return point; jump saves nothing
// - bit set/clear is read-modify-write, others kept
// - bit index selects bit 0 to 7
// - three moves: mem-acc, acc-mem, immediate-acc
// - eight-bit add carry, subtract borrow
// - increment/decrement by one, memory or accumulator
// - distinct logic ops through the accumulator
// - logical ops set zero on zero result
// - rotates by one, carry variants through carry
// - table read moves program word to data
// - power-down instruction halts execution
// - interrupt return sets global enable; return keeps
// - watchdog flags clear on consecutive pre-clears; halt also clears the timeout flag
`timescale 1ns/1ps

module mis_sequencer
	import mis_pkg::*;
#(
	parameter int STACK_DEPTH = 4
) (
	// clock and reset
	input  wire logic                    clk_sys_i,
	input  wire logic                    sys_rst_i,
	// program memory
	output logic [mis_pkg::PC_W-1:0]     pmem_addr_o,
	input  wire logic [mis_pkg::INSTR_W-1:0] pmem_data_i,
	// data memory
	output mis_pkg::mis_dmem_req_t       dmem_req_o,
	input  wire logic [mis_pkg::DATA_W-1:0] dmem_rdata_i,
	// system events
	input  wire logic                    wake_i,
	input  wire logic                    wdt_timeout_i,
	// core state
	output mis_pkg::mis_phase_t          phase_o,
	output mis_pkg::mis_status_t         status_o
);
	import mis_pkg::*;

	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mis_phase_t           phase_reg;
	mis_bub_t             bub_reg;
	mis_bub_t             bub_pend_reg;
	mis_instr_t           ir_reg;
	logic [PC_W-1:0]      pc_reg;
	logic [PC_W-1:0]      pmem_addr_reg;
	logic [PC_W-1:0]      tbl_addr_reg;
	logic [INSTR_W-1:0]   tbl_word_reg;
	logic [DATA_W-1:0]    tbl_high_reg;
	mis_dmem_req_t        dmem_req_reg;
	logic [DATA_W-1:0]    acc_reg;
	logic                 carry_reg;
	logic                 zero_reg;
	logic                 gie_reg;
	logic                 wdt_to_reg;
	logic                 pdf_reg;
	logic                 halted_reg;
	logic                 prev_pc1_reg;
	logic                 prev_pc2_reg;
	logic                 wake_meta_reg;
	logic                 wake_sync_reg;
	logic [SP_W-1:0]      sp_reg;
	logic [PC_W-1:0]      stack_reg [STACK_DEPTH];

	// execute-stage decisions
	logic                 exec_fire;
	logic [DATA_W-1:0]    res;
	logic [8:0]           sum;
	logic                 wr_acc;
	logic                 wr_mem;
	logic                 c_next;
	logic                 z_next;
	logic [PC_W-1:0]      pc_next;
	mis_bub_t             bub_next;
	logic                 push;
	logic                 pop;
	logic                 skip_op;
	logic                 skip_take;
	logic                 wdt_pair;
	logic [DATA_W-1:0]    bit_mask;
	logic [PC_W-1:0]      pc_inc;

	assign exec_fire = (phase_reg == PH_T3) && !halted_reg && (bub_reg == BUB_NONE);
	assign bit_mask  = BIT_ONE << ir_reg.bidx;
	assign pc_inc    = pc_reg + PC_STEP;
	assign wdt_pair  = exec_fire && (((ir_reg.op == OP_WDT_PC2) && prev_pc1_reg) ||
		((ir_reg.op == OP_WDT_PC1) && prev_pc2_reg));

	// outputs come straight from registers
	assign pmem_addr_o = pmem_addr_reg;
	assign dmem_req_o  = dmem_req_reg;
	assign phase_o     = phase_reg;
	assign status_o    = '{acc: acc_reg, tbl_high: tbl_high_reg, carry: carry_reg,
		zero: zero_reg, gie: gie_reg, wdt_to: wdt_to_reg, power_down_flag: pdf_reg,
		power_down: halted_reg};

	// ----------------------------------------------------------------
	// phase sequencing
	// ----------------------------------------------------------------
	// free-running ring; fetch in T1-T2, operand in T3, retire in T4
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_reg <= PH_T1;
		end else begin
			case (phase_reg)
				PH_T1:   phase_reg <= PH_T2;
				PH_T2:   phase_reg <= PH_T3;
				PH_T3:   phase_reg <= PH_T4;
				PH_T4:   phase_reg <= PH_T1;
				default: phase_reg <= PH_T1;
			endcase
		end
	end

	sequence seq_phase_walk;
		(phase_reg == PH_T2) ##1 (phase_reg == PH_T3) ##1 (phase_reg == PH_T4)
			##1 (phase_reg == PH_T1);
	endsequence
	phase_ring_a: assert property ((phase_reg == PH_T1) |=> seq_phase_walk)
		else $error("phase ring broke");
	reset_phase_a: assert property ($past(sys_rst_i) |-> (phase_reg == PH_T1))
		else $error("phase after reset not at first step");

	// wake pin passes two flip-flops before the halt logic sees it
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
		end else begin
			wake_meta_reg <= wake_i;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// fetch
	// ----------------------------------------------------------------
	// instruction word captured at the end of T2; a table cycle captures data instead
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ir_reg       <= '{op: OP_NOP, bidx: '0, m: BYTE_ZERO};
			tbl_word_reg <= '0;
		end else if (phase_reg == PH_T2) begin
			if (bub_reg == BUB_TABLE) begin
				tbl_word_reg <= pmem_data_i;
			end else begin
				ir_reg <= mis_instr_t'(pmem_data_i);
			end
		end
	end

	// program address moves once per cycle, at the end of T4
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pmem_addr_reg <= RESET_VECTOR;
			bub_reg       <= BUB_NONE;
		end else if (phase_reg == PH_T4) begin
			pmem_addr_reg <= (bub_pend_reg == BUB_TABLE) ? tbl_addr_reg : pc_reg;
			bub_reg       <= bub_pend_reg;
		end
	end

	// ----------------------------------------------------------------
	// execute decode
	// ----------------------------------------------------------------
	always_comb begin
		res       = acc_reg;
		sum       = 9'h000;
		wr_acc    = 1'b0;
		wr_mem    = 1'b0;
		c_next    = carry_reg;
		z_next    = zero_reg;
		pc_next   = pc_inc;
		bub_next  = BUB_NONE;
		push      = 1'b0;
		pop       = 1'b0;
		skip_op   = 1'b0;
		skip_take = 1'b0;
		case (ir_reg.op)
			OP_MOV_A_M: begin res = dmem_rdata_i; wr_acc = 1'b1; end
			OP_MOV_M_A: begin res = acc_reg; wr_mem = 1'b1; end
			OP_MOV_A_X: begin res = ir_reg.m; wr_acc = 1'b1; end
			OP_ADD_M, OP_ADD_X: begin
				sum    = {1'b0, acc_reg} + {1'b0, (ir_reg.op == OP_ADD_X) ? ir_reg.m : dmem_rdata_i};
				res    = sum[DATA_W-1:0];
				c_next = sum[DATA_W];
			end
			OP_SUB_M, OP_SUB_X: begin
				sum    = {1'b0, acc_reg} - {1'b0, (ir_reg.op == OP_SUB_X) ? ir_reg.m : dmem_rdata_i};
				res    = sum[DATA_W-1:0];
				c_next = ~sum[DATA_W];
			end
			OP_AND_M: res = acc_reg & dmem_rdata_i;
			OP_AND_X: res = acc_reg & ir_reg.m;
			OP_OR_M:  res = acc_reg | dmem_rdata_i;
			OP_XOR_M: res = acc_reg ^ dmem_rdata_i;
			OP_CPL:   res = ~dmem_rdata_i;
			OP_INC:   res = dmem_rdata_i + BIT_ONE;
			OP_DEC:   res = dmem_rdata_i - BIT_ONE;
			OP_RR:    res = {dmem_rdata_i[0], dmem_rdata_i[DATA_W-1:1]};
			OP_RL:    res = {dmem_rdata_i[DATA_W-2:0], dmem_rdata_i[DATA_W-1]};
			OP_RRC: begin
				res    = {carry_reg, dmem_rdata_i[DATA_W-1:1]};
				c_next = dmem_rdata_i[0];
			end
			OP_RLC: begin
				res    = {dmem_rdata_i[DATA_W-2:0], carry_reg};
				c_next = dmem_rdata_i[DATA_W-1];
			end
			OP_CLR_BIT: begin res = dmem_rdata_i & ~bit_mask; wr_mem = 1'b1; end
			OP_SET_BIT: begin res = dmem_rdata_i | bit_mask; wr_mem = 1'b1; end
			OP_SZ: begin
				skip_op   = 1'b1;
				skip_take = (dmem_rdata_i == BYTE_ZERO);
			end
			OP_SZ_BIT: begin
				skip_op   = 1'b1;
				skip_take = ((dmem_rdata_i & bit_mask) == BYTE_ZERO);
			end
			OP_SNZ_BIT: begin
				skip_op   = 1'b1;
				skip_take = ((dmem_rdata_i & bit_mask) != BYTE_ZERO);
			end
			OP_JMP: begin pc_next = {ir_reg.bidx, ir_reg.m}; bub_next = BUB_HOLD; end
			OP_CALL: begin
				pc_next  = {ir_reg.bidx, ir_reg.m};
				bub_next = BUB_HOLD;
				push     = 1'b1;
			end
			OP_RET, OP_INTERRUPT_RETURN_OP: begin
				pc_next  = stack_reg[sp_reg - SP_W'(1)];
				bub_next = BUB_HOLD;
				pop      = 1'b1;
			end
			OP_TABRD: bub_next = BUB_TABLE;
			default: ;
		endcase
		// memory-operand data operations pick accumulator or memory by the destination bit; immediate ones always write the accumulator
		case (ir_reg.op)
			OP_ADD_M, OP_SUB_M, OP_AND_M, OP_OR_M, OP_XOR_M, OP_CPL, OP_INC, OP_DEC,
			OP_RR, OP_RL, OP_RRC, OP_RLC: begin
				wr_mem = ir_reg.bidx[DEST_SEL_BIT];
				wr_acc = !ir_reg.bidx[DEST_SEL_BIT];
				z_next = (res == BYTE_ZERO);
			end
			OP_ADD_X, OP_SUB_X, OP_AND_X: begin
				wr_acc = 1'b1;
				z_next = (res == BYTE_ZERO);
			end
			default: ;
		endcase
		// all rotates, plain and through carry, leave the zero flag alone
		if (ir_reg.op == OP_RR || ir_reg.op == OP_RL || ir_reg.op == OP_RRC ||
			ir_reg.op == OP_RLC) begin
			z_next = zero_reg;
		end
		if (skip_take) begin
			bub_next = BUB_SKIP;
		end
		// a store to program_counter_low is a jump within the current page
		if (wr_mem && ir_reg.m == PCL_ADDR) begin
			wr_mem   = 1'b0;
			pc_next  = {pc_reg[PC_W-1:DATA_W], res};
			bub_next = BUB_HOLD;
		end
	end

	// ----------------------------------------------------------------
	// retire: program counter and bubble
	// ----------------------------------------------------------------
	// a skip bubble steps over the discarded word; hold and table bubbles keep the target
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pc_reg       <= RESET_VECTOR;
			bub_pend_reg <= BUB_NONE;
			tbl_addr_reg <= RESET_VECTOR;
		end else if (exec_fire) begin
			pc_reg       <= pc_next;
			bub_pend_reg <= bub_next;
			tbl_addr_reg <= {ir_reg.bidx, acc_reg};
		end else if (phase_reg == PH_T3 && !halted_reg) begin
			if (bub_reg == BUB_SKIP) begin
				pc_reg <= pc_inc;
			end
			bub_pend_reg <= BUB_NONE;
		end
	end

	two_cycle_a: assert property (exec_fire && (ir_reg.op inside {OP_JMP, OP_CALL, OP_RET,
		OP_INTERRUPT_RETURN_OP, OP_TABRD}) |-> ##4 !exec_fire ##4 (exec_fire || halted_reg))
		else $error("two-cycle instruction timing wrong");
	pcl_extra_a: assert property (exec_fire && (bub_next == BUB_HOLD) && ir_reg.m == PCL_ADDR &&
		!(ir_reg.op inside {OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN_OP}) |-> ##4 !exec_fire)
		else $error("counter-low write missed its extra cycle");
	skip_none_a: assert property (exec_fire && skip_op && !skip_take |-> ##4 exec_fire)
		else $error("untaken skip cost an extra cycle");
	skip_target_a: assert property (exec_fire && skip_take
		|-> ##4 !exec_fire ##1 (pc_reg == $past(pc_reg, 5) + 11'h002))
		else $error("taken skip did not land two words on");

	// ----------------------------------------------------------------
	// return stack
	// ----------------------------------------------------------------
	// overflow wraps silently, as a fixed-depth stack does
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sp_reg <= '0;
		end else if (exec_fire && push) begin
			sp_reg <= sp_reg + SP_W'(1);
		end else if (exec_fire && pop) begin
			sp_reg <= sp_reg - SP_W'(1);
		end
	end

	for (genvar gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
		always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				stack_reg[gi] <= RESET_VECTOR;
			end else if (exec_fire && push && sp_reg == SP_W'(gi)) begin
				stack_reg[gi] <= pc_inc;
			end
		end
	end

	call_save_a: assert property (exec_fire && ir_reg.op == OP_CALL
		|=> stack_reg[$past(sp_reg)] == $past(pc_reg) + 11'h001)
		else $error("call saved wrong return point");
	jump_nosave_a: assert property (exec_fire && ir_reg.op == OP_JMP |=> $stable(sp_reg))
		else $error("jump touched the stack");

	// ----------------------------------------------------------------
	// data path registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			acc_reg   <= BYTE_ZERO;
			carry_reg <= 1'b0;
			zero_reg  <= 1'b0;
		end else if (exec_fire) begin
			if (wr_acc) begin
				acc_reg <= res;
			end
			carry_reg <= c_next;
			zero_reg  <= z_next;
		end
	end

	// data address set in T2, write strobe lasts exactly T4
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dmem_req_reg <= '{addr: BYTE_ZERO, wdata: BYTE_ZERO, we: 1'b0};
			tbl_high_reg <= BYTE_ZERO;
		end else begin
			dmem_req_reg.we <= 1'b0;
			if (phase_reg == PH_T2 && bub_reg != BUB_TABLE) begin
				dmem_req_reg.addr <= pmem_data_i[DATA_W-1:0];
			end
			if (exec_fire) begin
				dmem_req_reg.we    <= wr_mem;
				dmem_req_reg.wdata <= res;
			end else if (phase_reg == PH_T3 && !halted_reg && bub_reg == BUB_TABLE) begin
				dmem_req_reg.we    <= 1'b1;
				dmem_req_reg.wdata <= tbl_word_reg[DATA_W-1:0];
				tbl_high_reg       <= tbl_word_reg[INSTR_W-1:DATA_W];
			end
		end
	end

	bit_rmw_a: assert property (exec_fire && ir_reg.op == OP_SET_BIT |=> dmem_req_reg.we &&
		dmem_req_reg.wdata == ($past(dmem_rdata_i) | (8'h01 << $past(ir_reg.bidx))))
		else $error("bit set changed other bits");
	add_carry_a: assert property (exec_fire && (ir_reg.op inside {OP_ADD_M, OP_ADD_X})
		|=> carry_reg == (({1'b0, $past(acc_reg)} + {1'b0, $past((ir_reg.op == OP_ADD_X) ?
		ir_reg.m : dmem_rdata_i)}) > BYTE_MAX))
		else $error("add carry wrong");
	logic_zero_a: assert property (exec_fire && (ir_reg.op inside {OP_AND_M, OP_OR_M,
		OP_XOR_M, OP_CPL, OP_AND_X}) |=> zero_reg == ($past(res) == 8'h00))
		else $error("zero flag wrong after logic op");
	rotate_carry_a: assert property (exec_fire && ir_reg.op == OP_RRC
		|=> carry_reg == $past(dmem_rdata_i[0]))
		else $error("rotate did not move bit into carry");

	// ----------------------------------------------------------------
	// control flags
	// ----------------------------------------------------------------
	// halt sets at execute; a synchronised wake releases at the cycle boundary
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			halted_reg <= 1'b0;
		end else if (exec_fire && ir_reg.op == OP_HALT) begin
			halted_reg <= 1'b1;
		end else if (phase_reg == PH_T4 && wake_sync_reg) begin
			halted_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gie_reg <= 1'b0;
		end else if (exec_fire && ir_reg.op == OP_INTERRUPT_RETURN_OP) begin
			gie_reg <= 1'b1;
		end
	end

	// timeout event beats a clear landing in the same clock
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wdt_to_reg   <= 1'b0;
			pdf_reg      <= 1'b0;
			prev_pc1_reg <= 1'b0;
			prev_pc2_reg <= 1'b0;
		end else begin
			if (wdt_timeout_i) begin
				wdt_to_reg <= 1'b1;
			end else if (wdt_pair || (exec_fire && ir_reg.op == OP_HALT)) begin
				wdt_to_reg <= 1'b0;
			end
			if (exec_fire && ir_reg.op == OP_HALT) begin
				pdf_reg <= 1'b1;
			end else if (wdt_pair) begin
				pdf_reg <= 1'b0;
			end
			if (exec_fire) begin
				prev_pc1_reg <= (ir_reg.op == OP_WDT_PC1) && !wdt_pair;
				prev_pc2_reg <= (ir_reg.op == OP_WDT_PC2) && !wdt_pair;
			end
		end
	end

	halt_a: assert property (exec_fire && ir_reg.op == OP_HALT
		|=> halted_reg ##4 !exec_fire)
		else $error("halt did not stop execution");
	interrupt_return_op_gie_a: assert property (exec_fire && ir_reg.op == OP_INTERRUPT_RETURN_OP |=> gie_reg)
		else $error("interrupt return left enable low");
	ret_gie_a: assert property (exec_fire && ir_reg.op == OP_RET |=> $stable(gie_reg))
		else $error("plain return changed enable");
	wdt_pair_a: assert property (wdt_pair && !wdt_timeout_i |=> !wdt_to_reg && !pdf_reg)
		else $error("pre-clear pair left flags set");
	wdt_single_a: assert property (exec_fire && ir_reg.op == OP_WDT_PC1 && !wdt_pair
		&& !wdt_timeout_i |=> $stable(pdf_reg))
		else $error("single pre-clear changed flag");

endmodule

/* File: tb/mis_mem_model.sv */
// mis_mem_model: program and data memory facing the instruction sequencer.
// assumes one clock; the bench loads program and data through the arrays.
`timescale 1ns/1ps

module mis_mem_model
	import mis_pkg::*;
#(
	parameter bit SLOW = 1'b1
) (
	// clock
	input  wire logic                       clk_sys_i,
	// program memory
	input  wire logic [mis_pkg::PC_W-1:0]   pmem_addr_i,
	output logic [mis_pkg::INSTR_W-1:0]     pmem_data_o,
	// data memory
	input  wire mis_pkg::mis_dmem_req_t     dmem_req_i,
	output logic [mis_pkg::DATA_W-1:0]      dmem_rdata_o
);
	logic [INSTR_W-1:0] pmem [0:2047];
	logic [DATA_W-1:0]  dmem [0:255];
	logic [INSTR_W-1:0] pd_reg;

	initial begin
		for (int i = 0; i < 2048; i++) pmem[i] = 16'h0000;
		for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
	end

	// slow mode answers program fetches one clock late, the latest the phases allow;
	// data reads stay combinational, as the address lands only one clock before use
	always @(posedge clk_sys_i) begin
		pd_reg <= pmem[pmem_addr_i];
		if (dmem_req_i.we) begin
			dmem[dmem_req_i.addr] <= dmem_req_i.wdata;
		end
	end

	assign pmem_data_o  = SLOW ? pd_reg : pmem[pmem_addr_i];
	assign dmem_rdata_o = dmem[dmem_req_i.addr];
endmodule

/* File: tb/tb.sv */
// tb: runs one program through the sequencer and judges timing and results.
// assumes the memory model fetches one clock late; reset held 4 clocks.
`timescale 1ns/1ps

module tb;
	import mis_pkg::*;
	logic                  clk_sys_i;
	logic                  sys_rst_i;
	logic                  wake_i;
	logic                  wdt_timeout_i;
	logic [PC_W-1:0]       pmem_addr_o;
	logic [INSTR_W-1:0]    pmem_data_i;
	logic [DATA_W-1:0]     dmem_rdata_i;
	mis_dmem_req_t         dmem_req_o;
	mis_phase_t            phase_o;
	mis_status_t           status_o;
	int                    bad_count = 0;
	int                    checked = 0;

	mis_sequencer u_mis_sequencer (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data_i), .dmem_req_o(dmem_req_o),
		.dmem_rdata_i(dmem_rdata_i), .wake_i(wake_i), .wdt_timeout_i(wdt_timeout_i),
		.phase_o(phase_o), .status_o(status_o));
	mis_mem_model u_mis_mem_model (.clk_sys_i(clk_sys_i), .pmem_addr_i(pmem_addr_o),
		.pmem_data_o(pmem_data_i), .dmem_req_i(dmem_req_o), .dmem_rdata_o(dmem_rdata_i));

	// 125 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic pm(input logic [10:0] a, input mis_op_t op, input logic [2:0] b,
		input logic [7:0] m);
		u_mis_mem_model.pmem[a] = {op, b, m};
	endtask

	// clocks until the fetch address reaches a, judged as whole instruction cycles;
	// a taken branch shows its target at once, so its hold cycle lands in the next step
	task automatic step(input logic [10:0] a, input int n);
		int c;
		c = 0;
		while (pmem_addr_o !== a && c < 400) begin
			@(negedge clk_sys_i);
			c++;
		end
		if (c >= 400) begin
			bad_count++;
			conclude();
		end
		check(c, 4 * n);
	endtask

	task automatic sc_reset_phase();
		mis_phase_t seq [4];
		seq = '{PH_T2, PH_T3, PH_T4, PH_T1};
		check(phase_o, PH_T1);
		sys_rst_i = 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_sys_i);
			check(phase_o, seq[i]);
		end
		check(pmem_addr_o, 11'h001);
	endtask

	task automatic sc_arith_move();
		fork
			begin
				@(negedge clk_sys_i);
				wdt_timeout_i = 1'b1;
				@(negedge clk_sys_i);
				wdt_timeout_i = 1'b0;
			end
		join_none
		step(11'h002, 1);
		check({status_o.acc, status_o.carry}, {8'h10, 1'b1});
		step(11'h003, 1);
		check(u_mis_mem_model.dmem[8'h10], 8'h10);
	endtask

	task automatic sc_bits_skip();
		step(11'h004, 1);
		check(u_mis_mem_model.dmem[8'h10], 8'h90);
		step(11'h005, 1);
		step(11'h007, 2);
	endtask

	task automatic sc_call_jump();
		step(11'h020, 1);
		step(11'h008, 2);
		check(status_o.gie, 1'b1);
		step(11'h030, 2);
	endtask

	task automatic sc_pcl_rotate();
		step(11'h031, 2);
		check({status_o.acc, status_o.zero}, {8'h00, 1'b1});
		step(11'h032, 1);
		step(11'h040, 1);
		check(u_mis_mem_model.dmem[8'h06], 8'h5A);
		step(11'h041, 2);
		check({status_o.acc, status_o.carry}, {8'hC8, 1'b0});
	endtask

	task automatic sc_wdt_halt();
		int c;
		step(11'h045, 4);
		check(status_o.wdt_to, 1'b1);
		step(11'h047, 2);
		check(status_o.wdt_to, 1'b0);
		repeat (16) @(negedge clk_sys_i);
		check({status_o.power_down, status_o.power_down_flag}, 2'b11);
		check(status_o.acc, 8'hC8);
		wake_i = 1'b1;
		c = 0;
		while (pmem_addr_o !== 11'h049 && c < 100) begin
			@(negedge clk_sys_i);
			c++;
		end
		check(pmem_addr_o, 11'h049);
		check({status_o.power_down, status_o.acc}, 9'h060);
	endtask

	// table word lands split over data memory and the high-byte status field
	task automatic sc_table_ret();
		step(11'h760, 1);
		step(11'h04A, 1);
		check({status_o.tbl_high, u_mis_mem_model.dmem[8'h11]}, 16'hBEEF);
		step(11'h050, 1);
		step(11'h04B, 2);
		check(status_o.gie, 1'b1);
	endtask

	// main sequence: program loaded while reset is held
	initial begin
		sys_rst_i = 1'b1;
		wake_i = 1'b0;
		wdt_timeout_i = 1'b0;
		@(negedge clk_sys_i);
		pm(11'h000, OP_MOV_A_X, 3'h0, 8'hF0);
		pm(11'h001, OP_ADD_X, 3'h0, 8'h20);
		pm(11'h002, OP_MOV_M_A, 3'h1, 8'h10);
		pm(11'h003, OP_SET_BIT, 3'h7, 8'h10);
		pm(11'h004, OP_SZ_BIT, 3'h4, 8'h10);
		pm(11'h005, OP_SNZ_BIT, 3'h4, 8'h10);
		pm(11'h006, OP_HALT, 3'h0, 8'h00);
		pm(11'h007, OP_CALL, 3'h0, 8'h20);
		pm(11'h020, OP_INTERRUPT_RETURN_OP, 3'h0, 8'h00);
		pm(11'h008, OP_JMP, 3'h0, 8'h30);
		pm(11'h030, OP_AND_X, 3'h0, 8'h00);
		pm(11'h031, OP_MOV_A_X, 3'h0, 8'h40);
		pm(11'h032, OP_MOV_M_A, 3'h1, 8'h06);
		pm(11'h040, OP_RRC, 3'h0, 8'h10);
		pm(11'h041, OP_WDT_PC1, 3'h0, 8'h00);
		pm(11'h043, OP_WDT_PC2, 3'h0, 8'h00);
		pm(11'h045, OP_WDT_PC1, 3'h0, 8'h00);
		pm(11'h046, OP_WDT_PC2, 3'h0, 8'h00);
		pm(11'h047, OP_HALT, 3'h0, 8'h00);
		pm(11'h048, OP_MOV_A_X, 3'h0, 8'h60);
		pm(11'h049, OP_TABRD, 3'h7, 8'h11);
		pm(11'h04A, OP_CALL, 3'h0, 8'h50);
		pm(11'h050, OP_RET, 3'h0, 8'h00);
		u_mis_mem_model.pmem[11'h760] = 16'hBEEF;
		u_mis_mem_model.dmem[8'h06] = 8'h5A;
		repeat (3) @(negedge clk_sys_i);
		sc_reset_phase();
		sc_arith_move();
		sc_bits_skip();
		sc_call_jump();
		sc_pcl_rotate();
		sc_wdt_halt();
		sc_table_ret();
		conclude();
	end
endmodule
